// ==== rtl/cub_stage.v ====
/*
   Current unbalance protection stage with Avalon-MM register access.
   Assumes phase phasors arrive synchronous to mclk_in with a valid
   strobe, and that time stamps and select signals come from elsewhere.
*/
`timescale 1ns/1ps
`include "cub_map.vh"

module cub_stage #(
   parameter W = 16,
   parameter TICK_CYC = `CUB_CLK_PER_MS,
   parameter FORCE_MS = `CUB_FORCE_MS,
   parameter INV_CAP_MS = `CUB_INV_CAP_MS
)(
   // Clock and reset.
   input wire mclk_in,
   input wire rstn_in,
   // Avalon-MM slave.
   input wire [7:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   output wire [31:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   // Phase current phasors.
   input wire sample_valid_in,
   input wire signed [W-1:0] l1_re_in,
   input wire signed [W-1:0] l1_im_in,
   input wire signed [W-1:0] l2_re_in,
   input wire signed [W-1:0] l2_im_in,
   input wire signed [W-1:0] l3_re_in,
   input wire signed [W-1:0] l3_im_in,
   // Group select sources, blocking and time stamp.
   input wire [7:0] digital_input_in,
   input wire [7:0] virtual_input_in,
   input wire [7:0] indicator_signal_n_in,
   input wire [7:0] virtual_output_in,
   input wire block_in,
   input wire [31:0] timestamp_in,
   // Stage status and events.
   output wire start_out,
   output wire trip_out,
   output wire blocked_out,
   output wire force_out,
   output wire [1:0] active_group_out,
   output wire evt_start_on_out,
   output wire evt_start_off_out,
   output wire evt_trip_on_out,
   output wire evt_trip_off_out
);

   localparam AW = W + 4;
   localparam signed [17:0] SQ = {2'b00, `CUB_SQRT3_HALF_Q15};

   ////////////////////////////////////////////////////////////////////////
   // Symmetrical components.

   wire signed [W+17:0] p2r = l2_re_in * SQ;
   wire signed [W+17:0] p2i = l2_im_in * SQ;
   wire signed [W+17:0] p3r = l3_re_in * SQ;
   wire signed [W+17:0] p3i = l3_im_in * SQ;
   wire signed [AW-1:0] s2r = p2r[AW+14:15];
   wire signed [AW-1:0] s2i = p2i[AW+14:15];
   wire signed [AW-1:0] s3r = p3r[AW+14:15];
   wire signed [AW-1:0] s3i = p3i[AW+14:15];
   wire signed [AW-1:0] e1r = l1_re_in;
   wire signed [AW-1:0] e1i = l1_im_in;
   wire signed [AW-1:0] h2r = l2_re_in >>> 1;
   wire signed [AW-1:0] h2i = l2_im_in >>> 1;
   wire signed [AW-1:0] h3r = l3_re_in >>> 1;
   wire signed [AW-1:0] h3i = l3_im_in >>> 1;
   wire signed [AW-1:0] nxt_i1r = e1r - h2r - s2i - h3r + s3i;
   wire signed [AW-1:0] nxt_i1i = e1i + s2r - h2i - s3r - h3i;
   wire signed [AW-1:0] nxt_i2r = e1r - h2r + s2i - h3r - s3i;
   wire signed [AW-1:0] nxt_i2i = e1i - s2r - h2i + s3r - h3i;

   reg signed [AW-1:0] i1r_ff, i1i_ff, i2r_ff, i2i_ff;
   reg seq_vld_ff;
   wire [2*AW-1:0] mag1 = i1r_ff * i1r_ff + i1i_ff * i1i_ff;
   wire [2*AW-1:0] mag2 = i2r_ff * i2r_ff + i2i_ff * i2i_ff;

   ////////////////////////////////////////////////////////////////////////
   // Registers and settings.

   reg [31:0] ctrl_ff;
   reg force_ff;
   reg [15:0] motor_nom_ff;
   reg [2:0] log_sel_ff;
   reg [15:0] pick_ff [0:3];
   reg [15:0] delay_ff [0:3];
   reg inv_ff [0:3];
   reg [15:0] mult_ff [0:3];
   reg [31:0] start_cnt_ff, trip_cnt_ff;
   reg start_ff, trip_ff, start_d_ff, trip_d_ff;
   reg [3:0] evt_ff;
   reg [31:0] rdata_ff;
   reg wait_ff;
   reg block_d_ff;
   reg [1:0] grp_ff;

   wire motor = ctrl_ff[`CUB_CTRL_MOTOR];
   wire [1:0] man_grp = ctrl_ff[`CUB_CTRL_MAN_LO +: 2];
   wire [1:0] alt_grp = ctrl_ff[`CUB_CTRL_ALT_LO +: 2];
   wire [2:0] src = ctrl_ff[`CUB_CTRL_SRC_LO +: 3];
   wire [2:0] sidx = ctrl_ff[`CUB_CTRL_IDX_LO +: 3];
   wire [3:0] evt_en = ctrl_ff[`CUB_CTRL_EVT_LO +: 4];

   // A selected source line high picks the alternate group.
   reg sel_sig;
   always @*
   begin
      if (src == `CUB_SRC_DI)
         sel_sig = digital_input_in[sidx];
      else if (src == `CUB_SRC_VI)
         sel_sig = virtual_input_in[sidx];
      else if (src == `CUB_SRC_IND)
         sel_sig = indicator_signal_n_in[sidx];
      else if (src == `CUB_SRC_VO)
         sel_sig = virtual_output_in[sidx];
      else
         sel_sig = 1'b0;
   end
   wire [1:0] grp = sel_sig ? alt_grp : man_grp;

   wire [15:0] pickup = pick_ff[grp];
   wire is_inv = inv_ff[grp];
   wire [31:0] k2sq = pickup * pickup;

   ////////////////////////////////////////////////////////////////////////
   // Percent-squared divider, shared by both modes.

   wire [55:0] num = mag2 * `CUB_PCT2_SCALE;
   wire [55:0] den_mot = motor_nom_ff * motor_nom_ff * 4'd9;
   wire [55:0] den = motor ? den_mot : {{(56-2*AW){1'b0}}, mag1};
   reg [55:0] rem_ff, den_ff;
   reg [15:0] quo_ff, pct2_ff;
   reg [4:0] step_ff;
   reg busy_ff;
   wire [3:0] bit_i = step_ff[3:0] - 4'd1;
   wire [55:0] den_sh = den_ff << bit_i;

   ////////////////////////////////////////////////////////////////////////
   // Delay timing and fault tracking.

   reg [16:0] tick_cnt_ff;
   reg tick_ff;
   reg [43:0] acc_ff;
   reg [19:0] ms_ff, force_ms_ff;
   reg [51:0] thr_ff;
   reg [6:0] pct_ff;
   reg [15:0] max_ff;
   reg [31:0] stamp_ff;
   reg [2:0] log_wp_ff;
   reg [31:0] log_time_ff [0:7];
   reg [31:0] log_data_ff [0:7];
   reg [15:0] dly_ms_hi;

   wire [43:0] tgt_dt = delay_ff[grp] * `CUB_DELAY_TO_MS;
   wire [43:0] tgt_inv = mult_ff[grp] * `CUB_INV_TGT_SCALE;
   wire [43:0] tgt = is_inv ? tgt_inv : tgt_dt;
   // Inverse time integrates squared excess so no divider is needed.
   wire [31:0] excess = (pct2_ff > k2sq) ? pct2_ff - k2sq : 32'h0000_0000;
   wire [43:0] inc = is_inv ? {12'h000, excess} : 44'h000_0000_0001;
   wire [51:0] acc100 = ({8'h00, acc_ff} << 6) + ({8'h00, acc_ff} << 5) +
                        ({8'h00, acc_ff} << 2);
   wire above = pct2_ff > k2sq;
   wire below = pct2_ff < k2sq;
   wire timed_out = (acc_ff >= tgt) ||
                    (is_inv && ms_ff >= INV_CAP_MS);

   ////////////////////////////////////////////////////////////////////////
   // Bus access decode.

   wire req = avs_read_in | avs_write_in;
   wire wr = avs_write_in & ~wait_ff;
   wire [3:0] gidx = avs_address_in[7:4];
   wire is_grp = gidx >= `CUB_OFS_GRP_FIRST && gidx <= `CUB_OFS_GRP_LAST;
   wire [1:0] wg = gidx[1:0] - 2'd1;
   wire [2:0] log_rd = log_wp_ff - 3'd1 - log_sel_ff;

   reg [31:0] nxt_rdata;
   always @*
   begin
      if (avs_address_in == `CUB_OFS_CTRL)
         nxt_rdata = {ctrl_ff[31:2], force_ff, ctrl_ff[0]};
      else if (avs_address_in == `CUB_OFS_STATUS)
         nxt_rdata = {27'h000_0000, grp, trip_ff, start_ff, block_in};
      else if (avs_address_in == `CUB_OFS_START_COUNT)
         nxt_rdata = start_cnt_ff;
      else if (avs_address_in == `CUB_OFS_TRIP_COUNT)
         nxt_rdata = trip_cnt_ff;
      else if (is_grp && avs_address_in[3:2] == 2'd0)
         nxt_rdata = {16'h0000, pick_ff[wg]};
      else if (is_grp && avs_address_in[3:2] == 2'd1)
         nxt_rdata = {16'h0000, delay_ff[wg]};
      else if (is_grp && avs_address_in[3:2] == 2'd2)
         nxt_rdata = {31'h0000_0000, inv_ff[wg]};
      else if (is_grp)
         nxt_rdata = {16'h0000, mult_ff[wg]};
      else if (avs_address_in == `CUB_OFS_MEASURE)
         nxt_rdata = {16'h0000, pct2_ff};
      else if (avs_address_in == `CUB_OFS_MOTOR_NOM)
         nxt_rdata = {16'h0000, motor_nom_ff};
      else if (avs_address_in == `CUB_OFS_LOG_SEL)
         nxt_rdata = {29'h0000_0000, log_sel_ff};
      else if (avs_address_in == `CUB_OFS_LOG_TIME)
         nxt_rdata = log_time_ff[log_rd];
      else if (avs_address_in == `CUB_OFS_LOG_DATA)
         nxt_rdata = log_data_ff[log_rd];
      else
         nxt_rdata = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequential logic.

   integer k;
   always @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         i1r_ff <= {AW{1'b0}};
         i1i_ff <= {AW{1'b0}};
         i2r_ff <= {AW{1'b0}};
         i2i_ff <= {AW{1'b0}};
         seq_vld_ff <= 1'b0;
         ctrl_ff <= `CUB_CTRL_RESET;
         force_ff <= 1'b0;
         motor_nom_ff <= `CUB_MOTOR_NOM_RESET;
         log_sel_ff <= 3'd0;
         for (k = 0; k < 4; k = k + 1)
         begin
            pick_ff[k] <= `CUB_PICKUP_RESET;
            delay_ff[k] <= `CUB_DELAY_RESET;
            inv_ff[k] <= 1'b0;
            mult_ff[k] <= `CUB_MULT_RESET;
         end
         for (k = 0; k < 8; k = k + 1)
         begin
            log_time_ff[k] <= 32'h0000_0000;
            log_data_ff[k] <= 32'h0000_0000;
         end
         start_cnt_ff <= 32'h0000_0000;
         trip_cnt_ff <= 32'h0000_0000;
         start_ff <= 1'b0;
         trip_ff <= 1'b0;
         start_d_ff <= 1'b0;
         trip_d_ff <= 1'b0;
         evt_ff <= 4'h0;
         rdata_ff <= 32'h0000_0000;
         wait_ff <= 1'b1;
         rem_ff <= 56'h0;
         den_ff <= 56'h0;
         quo_ff <= 16'h0000;
         pct2_ff <= 16'h0000;
         step_ff <= 5'd0;
         busy_ff <= 1'b0;
         tick_cnt_ff <= 17'd0;
         tick_ff <= 1'b0;
         acc_ff <= 44'h0;
         ms_ff <= 20'd0;
         force_ms_ff <= 20'd0;
         thr_ff <= 52'h0;
         pct_ff <= 7'd0;
         max_ff <= 16'h0000;
         stamp_ff <= 32'h0000_0000;
         log_wp_ff <= 3'd0;
      end
      else
      begin
         // One wait cycle, then the request completes.
         wait_ff <= !(req && wait_ff);
         if (req && wait_ff)
            rdata_ff <= nxt_rdata;

         // Sequence phasors.
         seq_vld_ff <= sample_valid_in;
         if (sample_valid_in)
         begin
            i1r_ff <= nxt_i1r;
            i1i_ff <= nxt_i1i;
            i2r_ff <= nxt_i2r;
            i2i_ff <= nxt_i2i;
         end

         // Divider: a new sample starts it, results saturate at full scale.
         if (seq_vld_ff && !busy_ff)
         begin
            if (den == 56'h0)
               pct2_ff <= 16'h0000;
            else if (num >= (den << 16))
               pct2_ff <= 16'hFFFF;
            else
            begin
               rem_ff <= num;
               den_ff <= den;
               quo_ff <= 16'h0000;
               step_ff <= 5'd16;
               busy_ff <= 1'b1;
            end
         end
         else if (busy_ff)
         begin
            if (rem_ff >= den_sh)
            begin
               rem_ff <= rem_ff - den_sh;
               quo_ff[bit_i] <= 1'b1;
            end
            step_ff <= step_ff - 5'd1;
            if (step_ff == 5'd1)
            begin
               busy_ff <= 1'b0;
               pct2_ff <= (rem_ff >= den_sh) ?
                          (quo_ff | (16'h0001 << bit_i)) : quo_ff;
            end
         end

         // Millisecond tick.
         tick_ff <= (tick_cnt_ff == TICK_CYC - 1);
         tick_cnt_ff <= (tick_cnt_ff == TICK_CYC - 1) ? 17'd0 :
                        tick_cnt_ff + 17'd1;

         // Force flag, shared and self-clearing.
         if (force_ff && tick_ff)
            force_ms_ff <= force_ms_ff + 20'd1;
         if (force_ff && force_ms_ff >= FORCE_MS)
            force_ff <= 1'b0;

         // Stage decision; frozen while forced for testing, but blocking still clears it.
         if (block_in)
         begin
            start_ff <= 1'b0;
            trip_ff <= 1'b0;
         end
         else if (!force_ff)
         begin
            if (!start_ff && above)
            begin
               start_ff <= 1'b1;
               acc_ff <= 44'h0;
               ms_ff <= 20'd0;
               pct_ff <= 7'd0;
               thr_ff <= {8'h00, tgt};
               max_ff <= pct2_ff;
               stamp_ff <= timestamp_in;
            end
            else if (start_ff && below)
            begin
               start_ff <= 1'b0;
               trip_ff <= 1'b0;
            end
            else if (start_ff)
            begin
               if (pct2_ff > max_ff)
                  max_ff <= pct2_ff;
               if (tick_ff && !trip_ff)
               begin
                  acc_ff <= acc_ff + inc;
                  ms_ff <= ms_ff + 20'd1;
               end
               if (!trip_ff && timed_out)
               begin
                  trip_ff <= 1'b1;
                  pct_ff <= `CUB_PCT_FULL;
               end
               else if (!trip_ff && acc100 >= thr_ff &&
                        pct_ff < `CUB_PCT_FULL - 7'd1)
               begin
                  pct_ff <= pct_ff + 7'd1;
                  thr_ff <= thr_ff + {8'h00, tgt};
               end
            end
         end

         // Edges, counters, events and the fault log.
         start_d_ff <= start_ff;
         trip_d_ff <= trip_ff;
         evt_ff[0] <= start_ff & ~start_d_ff & evt_en[0];
         evt_ff[1] <= ~start_ff & start_d_ff & evt_en[1];
         evt_ff[2] <= trip_ff & ~trip_d_ff & evt_en[2];
         evt_ff[3] <= ~trip_ff & trip_d_ff & evt_en[3];
         if (start_d_ff && !start_ff)
         begin
            log_time_ff[log_wp_ff] <= stamp_ff;
            log_data_ff[log_wp_ff] <= {5'h00, {1'b0, grp} + 3'd1,
                                       1'b0, pct_ff, max_ff};
            log_wp_ff <= log_wp_ff + 3'd1;
         end

         // Register writes; a counter clear in the same cycle as a count leaves the counter at one.
         if (wr && avs_address_in == `CUB_OFS_START_COUNT)
            start_cnt_ff <= (start_ff && !start_d_ff) ? 32'h1 : 32'h0;
         else if (start_ff && !start_d_ff)
            start_cnt_ff <= start_cnt_ff + 32'h1;
         if (wr && avs_address_in == `CUB_OFS_TRIP_COUNT)
            trip_cnt_ff <= (trip_ff && !trip_d_ff) ? 32'h1 : 32'h0;
         else if (trip_ff && !trip_d_ff)
            trip_cnt_ff <= trip_cnt_ff + 32'h1;

         if (wr && avs_address_in == `CUB_OFS_CTRL)
         begin
            ctrl_ff <= avs_writedata_in;
            force_ff <= avs_writedata_in[`CUB_CTRL_FORCE];
            force_ms_ff <= 20'd0;
         end
         if (wr && force_ff && !block_in &&
             avs_address_in == `CUB_OFS_STATUS)
         begin
            start_ff <= avs_writedata_in[1];
            trip_ff <= avs_writedata_in[2];
         end
         if (wr && is_grp && avs_address_in[3:2] == 2'd0)
            pick_ff[wg] <= avs_writedata_in[15:0];
         if (wr && is_grp && avs_address_in[3:2] == 2'd1)
            delay_ff[wg] <= avs_writedata_in[15:0];
         if (wr && is_grp && avs_address_in[3:2] == 2'd2)
            inv_ff[wg] <= avs_writedata_in[0];
         if (wr && is_grp && avs_address_in[3:2] == 2'd3)
            mult_ff[wg] <= avs_writedata_in[15:0];
         if (wr && avs_address_in == `CUB_OFS_MOTOR_NOM)
            motor_nom_ff <= avs_writedata_in[15:0];
         if (wr && avs_address_in == `CUB_OFS_LOG_SEL)
            log_sel_ff <= avs_writedata_in[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign avs_readdata_out = rdata_ff;
   assign avs_waitrequest_out = wait_ff;
   assign start_out = start_ff;
   assign trip_out = trip_ff;
   assign blocked_out = block_d_ff;
   assign force_out = force_ff;
   assign active_group_out = grp_ff;
   assign evt_start_on_out = evt_ff[0];
   assign evt_start_off_out = evt_ff[1];
   assign evt_trip_on_out = evt_ff[2];
   assign evt_trip_off_out = evt_ff[3];

   // Registered copies keep these outputs straight off flip-flops.
   always @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         block_d_ff <= 1'b0;
         grp_ff <= 2'd0;
      end
      else
      begin
         block_d_ff <= block_in;
         grp_ff <= grp;
      end
   end

endmodule

// ==== rtl/cub_map.vh ====
/*
   Constants for the current unbalance protection stage: register byte
   offsets, field positions, reset values and timing figures.
   Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
`ifndef CUB_MAP_VH
`define CUB_MAP_VH

`define CUB_CLK_NS 8
`define CUB_MS_NS 1000000
`define CUB_CLK_PER_MS (`CUB_MS_NS / `CUB_CLK_NS)
`define CUB_FORCE_TIMEOUT_S 300
`define CUB_FORCE_MS (`CUB_FORCE_TIMEOUT_S * 1000)
`define CUB_INV_MAX_S 1000
`define CUB_INV_CAP_MS (`CUB_INV_MAX_S * 1000)

`define CUB_OFS_CTRL 8'h00
`define CUB_OFS_STATUS 8'h04
`define CUB_OFS_START_COUNT 8'h08
`define CUB_OFS_TRIP_COUNT 8'h0C
`define CUB_OFS_GRP_FIRST 4'h1
`define CUB_OFS_GRP_LAST 4'h4
`define CUB_OFS_MEASURE 8'h50
`define CUB_OFS_MOTOR_NOM 8'h54
`define CUB_OFS_LOG_SEL 8'h58
`define CUB_OFS_LOG_TIME 8'h5C
`define CUB_OFS_LOG_DATA 8'h60

`define CUB_CTRL_MOTOR 0
`define CUB_CTRL_FORCE 1
`define CUB_CTRL_MAN_LO 2
`define CUB_CTRL_ALT_LO 4
`define CUB_CTRL_SRC_LO 6
`define CUB_CTRL_IDX_LO 9
`define CUB_CTRL_EVT_LO 12
`define CUB_CTRL_RESET 32'h0000_F000

`define CUB_SRC_NONE 3'h0
`define CUB_SRC_DI 3'h1
`define CUB_SRC_VI 3'h2
`define CUB_SRC_IND 3'h3
`define CUB_SRC_VO 3'h4

`define CUB_PICKUP_RESET 16'h0014
`define CUB_DELAY_RESET 16'h0064
`define CUB_MULT_RESET 16'h000F
`define CUB_MOTOR_NOM_RESET 16'h1000
`define CUB_SQRT3_HALF_Q15 16'h6EDA
`define CUB_PCT2_SCALE 16'h2710
`define CUB_DELAY_TO_MS 8'h64
`define CUB_INV_TGT_SCALE 24'h98_9680
`define CUB_PCT_FULL 7'h64

`endif

// ==== bench/cub_asserts.sv ====
/*
   Port checker for the unbalance stage, bound onto cub_stage.
   Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module cub_asserts (
   // Clock, reset and bus handshake.
   input wire mclk_in,
   input wire rstn_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire avs_waitrequest_out,
   // Stage status and events.
   input wire block_in,
   input wire start_out,
   input wire trip_out,
   input wire blocked_out,
   input wire force_out,
   input wire evt_start_on_out,
   input wire evt_start_off_out,
   input wire evt_trip_on_out,
   input wire evt_trip_off_out
);
   default clocking dck @(posedge mclk_in);
   endclocking
   default disable iff (!rstn_in);
   ////////////////////////////////////////////////////////////////////////
   property p_req_ack;
      (avs_read_in || avs_write_in) && avs_waitrequest_out
         |=> !avs_waitrequest_out;
   endproperty
   a_req_ack: assert property (p_req_ack) else $error("bus answer late");
   property p_blk_follow;
      blocked_out == $past(block_in);
   endproperty
   a_blk_follow: assert property (p_blk_follow) else $error("blocked lag");
   // Forcing may legally hold any status, so these skip forced cycles.
   property p_blk_clear;
      blocked_out && !force_out |-> !start_out && !trip_out;
   endproperty
   a_blk_clear: assert property (p_blk_clear) else $error("blocked active");
   property p_trip_start;
      trip_out && !force_out && !$past(force_out) |-> start_out;
   endproperty
   a_trip_start: assert property (p_trip_start) else $error("lone trip");
   property p_ev_son;
      evt_start_on_out |-> $past(start_out) && !$past(start_out, 2);
   endproperty
   a_ev_son: assert property (p_ev_son) else $error("start on event");
   property p_ev_soff;
      evt_start_off_out |-> !$past(start_out) && $past(start_out, 2);
   endproperty
   a_ev_soff: assert property (p_ev_soff) else $error("start off event");
   property p_ev_ton;
      evt_trip_on_out |-> $past(trip_out) && !$past(trip_out, 2);
   endproperty
   a_ev_ton: assert property (p_ev_ton) else $error("trip on event");
   property p_ev_toff;
      evt_trip_off_out |-> !$past(trip_out) && $past(trip_out, 2);
   endproperty
   a_ev_toff: assert property (p_ev_toff) else $error("trip off event");
   c_trip: cover property (start_out ##1 trip_out);
   c_force_end: cover property (force_out ##1 !force_out);
   c_trip_off: cover property (evt_trip_off_out);
endmodule

bind cub_stage cub_asserts u_chk (
   .mclk_in(mclk_in), .rstn_in(rstn_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
   .block_in(block_in), .start_out(start_out), .trip_out(trip_out),
   .blocked_out(blocked_out), .force_out(force_out),
   .evt_start_on_out(evt_start_on_out), .evt_start_off_out(evt_start_off_out),
   .evt_trip_on_out(evt_trip_on_out), .evt_trip_off_out(evt_trip_off_out));

// ==== bench/cub_phase_src.sv ====
/*
   Phase current front end model: one phasor set every sixteen cycles.
   Assumes the stage reads phasors only with the valid strobe.
*/
`timescale 1ns/1ps
module cub_phase_src (
   // Clock and load choice.
   input wire mclk_in,
   input wire unbal_in,
   // Phasor stream.
   output logic sample_valid_out = 1'b0,
   output wire signed [15:0] l1_re_out,
   output wire signed [15:0] l1_im_out,
   output wire signed [15:0] l2_re_out,
   output wire signed [15:0] l2_im_out,
   output wire signed [15:0] l3_re_out,
   output wire signed [15:0] l3_im_out
);
   logic [3:0] cnt_ff = 4'h0;
   wire [15:0] mask = {16{~sample_valid_out}};
   ////////////////////////////////////////////////////////////////////////
   // Between strobes the lines carry inverted data, so a stage that
   // samples outside the strobe sees garbage instead of a lucky value.
   always @(posedge mclk_in)
   begin
      cnt_ff <= cnt_ff + 4'h1;
      sample_valid_out <= (cnt_ff == 4'hF);
   end
   assign l1_re_out = 16'h03E8 ^ mask;
   assign l1_im_out = 16'h0000 ^ mask;
   assign l2_re_out = (unbal_in ? 16'h0000 : 16'hFE0C) ^ mask;
   assign l2_im_out = (unbal_in ? 16'h0000 : 16'hFC9E) ^ mask;
   assign l3_re_out = (unbal_in ? 16'h0000 : 16'hFE0C) ^ mask;
   assign l3_im_out = (unbal_in ? 16'h0000 : 16'h0362) ^ mask;
endmodule

// ==== bench/tb_top.sv ====
/*
   Self-checking bench for the current unbalance stage.
   Assumes cub_stage, the phase source model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
   localparam int TICK = 10;
   logic mclk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [7:0] avs_address_in = 8'h00;
   logic [31:0] avs_writedata_in = 32'h0000_0000;
   logic block_in = 1'b0;
   logic unbal = 1'b0;
   logic [31:0] src_lines = 32'h0000_0000, rd;
   logic [31:0] stamp = 32'h0000_5A5A;
   wire [31:0] avs_readdata_out;
   wire avs_waitrequest_out, sample_valid_in, start_out, trip_out;
   wire blocked_out, force_out, evt_son, evt_soff, evt_ton, evt_toff;
   wire [1:0] active_group_out;
   wire signed [15:0] l1r, l1i, l2r, l2i, l3r, l3i;
   int n_errors = 0;
   int checks_done = 0;
   int n_evt = 0;
   int n, e;
   always #4 mclk_in = ~mclk_in;
   always @(posedge mclk_in)
      n_evt <= n_evt + evt_son + evt_soff + evt_ton + evt_toff;
   cub_phase_src u_src (.mclk_in(mclk_in), .unbal_in(unbal),
      .sample_valid_out(sample_valid_in), .l1_re_out(l1r), .l1_im_out(l1i),
      .l2_re_out(l2r), .l2_im_out(l2i), .l3_re_out(l3r), .l3_im_out(l3i));
   // Shortened ms tick and timeouts keep the run near eleven thousand cycles.
   cub_stage #(.TICK_CYC(TICK), .FORCE_MS(20), .INV_CAP_MS(50)) u_dut (
      .mclk_in(mclk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .sample_valid_in(sample_valid_in), .l1_re_in(l1r), .l1_im_in(l1i),
      .l2_re_in(l2r), .l2_im_in(l2i), .l3_re_in(l3r), .l3_im_in(l3i),
      .digital_input_in(src_lines[7:0]), .virtual_input_in(src_lines[15:8]),
      .indicator_signal_n_in(src_lines[23:16]),
      .virtual_output_in(src_lines[31:24]), .block_in(block_in),
      .timestamp_in(stamp), .start_out(start_out),
      .trip_out(trip_out), .blocked_out(blocked_out), .force_out(force_out),
      .active_group_out(active_group_out), .evt_start_on_out(evt_son),
      .evt_start_off_out(evt_soff), .evt_trip_on_out(evt_ton),
      .evt_trip_off_out(evt_toff));
   ////////////////////////////////////////////////////////////////////////
   task automatic tick(inout int k);
      @(posedge mclk_in);
      k++;
   endtask
   task automatic chk(input string what, input logic [31:0] lo, hi, got);
      checks_done++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         n_errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] q);
      int k = 0;
      avs_address_in <= a;
      avs_writedata_in <= wd;
      avs_write_in <= we;
      avs_read_in <= !we;
      do tick(k); while (avs_waitrequest_out !== 1'b0 && k < 50);
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic wait_lvl(input int which, input logic v, input int lim);
      n = 0;
      while ((which == 0 ? start_out : which == 1 ? trip_out : force_out)
         !== v && n < lim) tick(n);
   endtask
   task automatic t_defaults;
      logic [31:0] dflt [4] = '{32'h0000_0014, 32'h0000_0064, 32'h0000_0000,
         32'h0000_000F};
      bus(1'b0, 8'h00, 32'h0000_0000, rd);
      chk("ctrl", 32'h0000_F000, 32'h0000_F000, rd);
      for (int g = 0; g < 16; g++)
      begin
         bus(1'b0, 8'h10 + 8'(4 * g), 32'h0000_0000, rd);
         chk("group setting", dflt[g % 4], dflt[g % 4], rd);
      end
      bus(1'b0, 8'hFC, 32'h0000_0000, rd);
      chk("unmapped", 0, 0, rd);
      $display("test defaults done");
   endtask
   task automatic t_feeder;
      e = n_evt;
      bus(1'b1, 8'h00, 32'h0000_F004, rd);
      bus(1'b1, 8'h24, 32'h0000_000A, rd);
      chk("manual group", 1, 1, active_group_out);
      unbal <= 1'b1;
      wait_lvl(0, 1'b1, 400);
      chk("start", 1, 1, start_out);
      wait_lvl(1, 1'b1, 12000);
      chk("trip cycles", 1000 * TICK - 30, 1000 * TICK + 30, n);
      unbal <= 1'b0;
      wait_lvl(0, 1'b0, 400);
      chk("trip release", 0, 0, trip_out);
      bus(1'b0, 8'h08, 32'h0000_0000, rd);
      chk("start count", 1, 1, rd);
      bus(1'b0, 8'h0C, 32'h0000_0000, rd);
      chk("trip count", 1, 1, rd);
      bus(1'b0, 8'h5C, 32'h0000_0000, rd);
      chk("log stamp", 32'h0000_5A5A, 32'h0000_5A5A, rd);
      bus(1'b0, 8'h60, 32'h0000_0000, rd);
      chk("log delay pct", 100, 100, rd[22:16]);
      chk("log group", 2, 2, rd[26:24]);
      chk("log max", 9800, 10200, rd[15:0]);
      chk("events", e + 4, e + 4, n_evt);
      bus(1'b1, 8'h08, 32'h0000_0000, rd);
      bus(1'b0, 8'h08, 32'h0000_0000, rd);
      chk("count clear", 0, 0, rd);
      bus(1'b1, 8'h00, 32'h0000_F000, rd);
      $display("test feeder done");
   endtask
   task automatic t_motor;
      bus(1'b1, 8'h10, 32'h0000_0002, rd);
      bus(1'b1, 8'h18, 32'h0000_0001, rd);
      bus(1'b1, 8'h1C, 32'h0000_03E8, rd);
      bus(1'b1, 8'h00, 32'h0000_F001, rd);
      unbal <= 1'b1;
      wait_lvl(0, 1'b1, 400);
      wait_lvl(1, 1'b1, 2000);
      chk("inverse cap", 50 * TICK - 30, 50 * TICK + 30, n);
      bus(1'b0, 8'h50, 32'h0000_0000, rd);
      chk("motor value", 60, 72, rd);
      unbal <= 1'b0;
      wait_lvl(0, 1'b0, 400);
      bus(1'b1, 8'h10, 32'h0000_0014, rd);
      bus(1'b1, 8'h18, 32'h0000_0000, rd);
      bus(1'b1, 8'h00, 32'h0000_F000, rd);
      $display("test motor done");
   endtask
   task automatic t_force;
      bus(1'b1, 8'h04, 32'h0000_0006, rd);
      chk("unforced write", 0, 0, start_out);
      e = n_evt;
      bus(1'b1, 8'h00, 32'h0000_0002, rd);
      chk("force", 1, 1, force_out);
      bus(1'b1, 8'h04, 32'h0000_0006, rd);
      chk("forced status", 1, 1, start_out && trip_out);
      wait_lvl(2, 1'b0, 400);
      chk("force timeout", 20 * TICK - 30, 20 * TICK + 10, n);
      wait_lvl(0, 1'b0, 400);
      bus(1'b1, 8'h00, 32'h0000_F000, rd);
      chk("masked events", e, e, n_evt);
      $display("test force done");
   endtask
   task automatic t_group;
      for (int s = 0; s < 5; s++)
      begin
         src_lines <= s == 0 ? 32'hFFFF_FFFF : 32'h0000_0001 << (8 * (s - 1));
         bus(1'b1, 8'h00, 32'h0000_F020 | (32'(s) << 6), rd);
         bus(1'b0, 8'h04, 32'h0000_0000, rd);
         chk("group by source", s ? 2 : 0, s ? 2 : 0, rd[4:3]);
      end
      src_lines <= 32'h0000_0000;
      bus(1'b1, 8'h00, 32'h0000_F000, rd);
      $display("test group done");
   endtask
   task automatic t_block;
      block_in <= 1'b1;
      unbal <= 1'b1;
      wait_lvl(0, 1'b1, 200);
      chk("blocked start", 0, 0, start_out);
      bus(1'b0, 8'h04, 32'h0000_0000, rd);
      chk("blocked status", 1, 1, rd[0]);
      $display("test block done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge mclk_in);
      rstn_in <= 1'b1;
      @(posedge mclk_in);
      t_defaults();
      t_feeder();
      t_motor();
      t_force();
      t_group();
      t_block();
      tally_and_finish();
   end
   initial
   begin
      repeat (40000) @(posedge mclk_in);
      n_errors++;
      tally_and_finish();
   end
endmodule
